// ===== hw/sfp_pkg.sv
// Constants for the six-bit shared I/O port and its AHB-Lite registers.
// Assumes a 32-bit AHB-Lite bus with word-aligned single transfers.
package sfp_pkg;

	localparam int ADDR_W = 12;

	// Byte offsets of the register words
	localparam logic [11:0] OFF_PIN_LEVELS = 12'h000;
	localparam logic [11:0] OFF_LATCH = 12'h004;
	localparam logic [11:0] OFF_DIRECTION = 12'h008;
	localparam logic [11:0] OFF_SELECT_LOW = 12'h00c;
	localparam logic [11:0] OFF_SELECT_HIGH = 12'h010;
	localparam logic [11:0] OFF_WATCHDOG = 12'h014;

	// Word indexes as returned by the decoder
	localparam logic [2:0] IDX_PIN_LEVELS = 3'h0;
	localparam logic [2:0] IDX_LATCH = 3'h1;
	localparam logic [2:0] IDX_DIRECTION = 3'h2;
	localparam logic [2:0] IDX_SELECT_LOW = 3'h3;
	localparam logic [2:0] IDX_SELECT_HIGH = 3'h4;
	localparam logic [2:0] IDX_WATCHDOG = 3'h5;
	localparam logic [2:0] IDX_NONE = 3'h7;

	// Implemented bits of each register
	localparam logic [7:0] PORT_MASK = 8'hfc;
	localparam logic [7:0] SELECT_LOW_MASK = 8'h9f;
	localparam logic [7:0] SELECT_HIGH_MASK = 8'hfc;

	// Reset values
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] DIRECTION_RESET = 8'hfc;
	localparam logic [7:0] SELECT_RESET = 8'h00;
	localparam logic [7:0] DEFAULT_RESET = 8'h00;
	localparam logic [7:0] WATCHDOG_RESET = 8'h00;

	// Field positions
	localparam int WDT_SHARED_BIT = 4;
	localparam int CFG_PIN2_BIT = 7;
	localparam int CFG_PIN5_BIT = 2;
	localparam int CFG_PIN6_BIT = 3;

	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage

// ===== hw/sfp_pin_sync.sv
// Two-stage synchroniser for the six port pin inputs.
// Assumes pin levels are asynchronous to hclk.
`timescale 1ns/1ps
`default_nettype none

module sfp_pin_sync
(
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	input wire logic [7:2] d, // Raw pin levels
	output logic [7:2] q // Synchronised levels
);

	typedef struct packed {
		logic [7:2] meta;
		logic [7:2] stable;
	} sfp_sync_type;

	sfp_sync_type s;
	sfp_sync_type next_s;

	// First stage feeds only the second stage
	always_comb
	begin
		next_s = s;
		for (int i = 2; i <= 7; i++)
		begin
			next_s.meta[i] = d[i];
			next_s.stable[i] = s.meta[i];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign q = s.stable;

endmodule // sfp_pin_sync

`default_nettype wire

// ===== hw/sfp_port.sv
// Six-bit shared I/O port (pins 2..7) with AHB-Lite register access.
// Assumes peripheral sideband signals are synchronous to hclk and pins
// are asynchronous; pad drivers resolve pin_out/pin_oe externally.
//
// What this block does
// - Output direction drives pin from latch.
// - Analog enable kills digital read-back.
// - Pin 2 is analog after reset.
// - Pins 5, 6 are analog after reset.
// - USB transceiver owns pins 3 and 4.
// - Reference output disables pin 5 I/O.
// - Map bit 0 routes parallel data.
// - Parallel address bit 5 drives pin 2.
// - Peripherals override the direction bit.
// - Level, latch and direction bits 1 and 0 read zero.
// - Watchdog bit 4 exposes analog select.
// - Pins 3, 4 input-only when USB off.
// - Analog pins read as zero.
// - Direction bit 1 input, 0 output.
`timescale 1ns/1ps
`default_nettype none

module sfp_port
(
	input wire logic hclk, // System clock, 125 MHz
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // Slave select
	input wire logic [11:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic [1:0] hresp, // Response
	input wire logic [7:2] pin_in, // Pad input levels
	output logic [7:2] pin_out, // Pad output levels
	output logic [7:2] pin_oe, // Pad output enables
	input wire logic usb_transceiver_disable, // USB transceiver off
	input wire logic [1:0] usb_tx_data, // [0] minus, [1] plus
	input wire logic [1:0] usb_tx_oe, // Transceiver drive enables
	output logic [1:0] usb_rx_data, // Line levels to transceiver
	input wire logic parallel_pin_map_select, // 0: data on pins 5..7
	input wire logic parallel_data_en, // Parallel data port active
	input wire logic [2:0] parallel_data_out, // Data bits 2..0
	input wire logic [2:0] parallel_data_oe, // Data drive enables
	output logic [2:0] parallel_data_in, // Data bits from pins
	input wire logic parallel_addr_en, // Address bit 5 on pin 2
	input wire logic parallel_addr_bit5, // Address bit 5 value
	input wire logic comparator_reference_out_en, // Ref on pin 5
	input wire logic comparator_one_output, // Comparator 1 result
	input wire logic comparator_one_output_en, // Result on pin 7
	output logic serial_slave_select // Pin 7 level to serial unit
);

	typedef struct packed {
		logic [7:0] latch;
		logic [7:0] direction;
		logic [7:0] select_low;
		logic [7:0] select_high;
		logic [7:0] default_low;
		logic [7:0] default_high;
		logic [7:0] watchdog;
		logic wr_pend;
		logic [2:0] wr_idx;
		logic [7:2] pin_out;
		logic [7:2] pin_oe;
		logic [31:0] rdata;
		logic readyout;
		logic [1:0] usb_rx;
		logic [2:0] pmd_in;
		logic ss;
		logic [1:0] resp;
	} sfp_state_type;

	sfp_state_type s;
	sfp_state_type next_s;
	logic [7:2] pin_sync;
	logic [7:2] analog_on;
	logic [7:2] pin_digital;
	logic [7:0] pin_read;
	logic addr_phase;
	logic [2:0] addr_idx;
	logic shared_on;
	logic map_on;

	// Word decode shared by read and write paths
	function automatic logic [2:0] word_index(input logic [11:0] a);
		logic [2:0] idx;
		idx = sfp_pkg::IDX_NONE;
		case ({a[11:2], 2'h0})
			sfp_pkg::OFF_PIN_LEVELS: idx = sfp_pkg::IDX_PIN_LEVELS;
			sfp_pkg::OFF_LATCH: idx = sfp_pkg::IDX_LATCH;
			sfp_pkg::OFF_DIRECTION: idx = sfp_pkg::IDX_DIRECTION;
			sfp_pkg::OFF_SELECT_LOW: idx = sfp_pkg::IDX_SELECT_LOW;
			sfp_pkg::OFF_SELECT_HIGH: idx = sfp_pkg::IDX_SELECT_HIGH;
			sfp_pkg::OFF_WATCHDOG: idx = sfp_pkg::IDX_WATCHDOG;
			default: idx = sfp_pkg::IDX_NONE;
		endcase
		return idx;
	endfunction

	// Shared address shows the configuration only while exposed
	function automatic logic [7:0] shared_view(input logic on,
		input logic [7:0] cfg, input logic [7:0] dflt);
		return on ? cfg : dflt;
	endfunction

	sfp_pin_sync u_sync
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.d(pin_in),
		.q(pin_sync)
	);

	// Select bit 1 means digital, so reset leaves 2, 5, 6 analog
	always_comb
	begin
		analog_on = '0;
		analog_on[2] = ~s.select_low[sfp_pkg::CFG_PIN2_BIT];
		analog_on[5] = ~s.select_high[sfp_pkg::CFG_PIN5_BIT];
		analog_on[6] = ~s.select_high[sfp_pkg::CFG_PIN6_BIT];
	end

	// One digital input path for read-back and parallel data inputs, so a
	// dead pin cannot leak in through a parallel data input
	always_comb
	begin
		pin_digital = pin_sync & ~analog_on;
		if (comparator_reference_out_en)
			pin_digital[5] = 1'b0;
		pin_read = '0;
		pin_read[7:2] = pin_digital;
		pin_read = pin_read & sfp_pkg::PORT_MASK;
	end

	assign addr_phase = hsel & hready & htrans == sfp_pkg::HTRANS_NONSEQ;
	assign addr_idx = word_index(haddr);
	assign shared_on = s.watchdog[sfp_pkg::WDT_SHARED_BIT];
	assign map_on = parallel_data_en & ~parallel_pin_map_select;

	always_comb
	begin
		next_s = s;
		next_s.readyout = 1'b1;
		next_s.resp = sfp_pkg::HRESP_OKAY;

		// Data phase of a write: commit hwdata
		if (s.wr_pend)
		begin
			case (s.wr_idx)
				sfp_pkg::IDX_PIN_LEVELS,
				sfp_pkg::IDX_LATCH:
					next_s.latch = hwdata[7:0] & sfp_pkg::PORT_MASK;
				sfp_pkg::IDX_DIRECTION:
					next_s.direction = hwdata[7:0] & sfp_pkg::PORT_MASK;
				sfp_pkg::IDX_SELECT_LOW:
				begin
					if (shared_on)
						next_s.select_low =
							hwdata[7:0] & sfp_pkg::SELECT_LOW_MASK;
					else
						next_s.default_low = hwdata[7:0];
				end
				sfp_pkg::IDX_SELECT_HIGH:
				begin
					if (shared_on)
						next_s.select_high =
							hwdata[7:0] & sfp_pkg::SELECT_HIGH_MASK;
					else
						next_s.default_high = hwdata[7:0];
				end
				sfp_pkg::IDX_WATCHDOG:
					next_s.watchdog = hwdata[7:0];
				default:
					next_s.watchdog = s.watchdog;
			endcase
		end

		// Address phase: latch write target, prefetch read data
		next_s.wr_pend = addr_phase & hwrite;
		next_s.wr_idx = addr_idx;
		if (addr_phase && !hwrite)
		begin
			next_s.rdata = '0;
			case (addr_idx)
				sfp_pkg::IDX_PIN_LEVELS:
					next_s.rdata[7:0] = pin_read;
				sfp_pkg::IDX_LATCH:
					next_s.rdata[7:0] = s.latch;
				sfp_pkg::IDX_DIRECTION:
					next_s.rdata[7:0] = s.direction;
				sfp_pkg::IDX_SELECT_LOW:
					next_s.rdata[7:0] =
						shared_view(shared_on, s.select_low, s.default_low);
				sfp_pkg::IDX_SELECT_HIGH:
					next_s.rdata[7:0] =
						shared_view(shared_on, s.select_high, s.default_high);
				sfp_pkg::IDX_WATCHDOG:
					next_s.rdata[7:0] = s.watchdog;
				default:
					next_s.rdata = '0;
			endcase
		end

		// Plain port: direction 0 drives the latch, analog does not block
		next_s.pin_oe = ~s.direction[7:2];
		next_s.pin_out = s.latch[7:2];

		if (parallel_addr_en)
		begin
			next_s.pin_oe[2] = 1'b1;
			next_s.pin_out[2] = parallel_addr_bit5;
		end

		// Pins 3 and 4 never drive from the latch
		if (usb_transceiver_disable)
		begin
			next_s.pin_oe[3] = 1'b0;
			next_s.pin_oe[4] = 1'b0;
		end
		else
		begin
			next_s.pin_oe[4:3] = usb_tx_oe;
			next_s.pin_out[4:3] = usb_tx_data;
		end

		// Comparator output on pin 7, below parallel data
		if (comparator_one_output_en)
		begin
			next_s.pin_oe[7] = 1'b1;
			next_s.pin_out[7] = comparator_one_output;
		end

		// Data bit 2 on pin 5, bit 1 on pin 6, bit 0 on pin 7
		if (map_on)
		begin
			for (int i = 0; i < 3; i++)
			begin
				next_s.pin_oe[7 - i] = parallel_data_oe[i];
				next_s.pin_out[7 - i] = parallel_data_out[i];
			end
		end

		// Reference output owns pin 5 outright
		if (comparator_reference_out_en)
			next_s.pin_oe[5] = 1'b0;

		// Sideband inputs to peripherals
		next_s.usb_rx = pin_sync[4:3];
		for (int i = 0; i < 3; i++)
			next_s.pmd_in[i] = map_on & pin_digital[7 - i];
		// Valid only while direction bit 7 is set by software
		next_s.ss = pin_sync[7];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s <= '0;
			s.latch <= sfp_pkg::LATCH_RESET;
			s.direction <= sfp_pkg::DIRECTION_RESET;
			s.select_low <= sfp_pkg::SELECT_RESET;
			s.select_high <= sfp_pkg::SELECT_RESET;
			s.default_low <= sfp_pkg::DEFAULT_RESET;
			s.default_high <= sfp_pkg::DEFAULT_RESET;
			s.watchdog <= sfp_pkg::WATCHDOG_RESET;
			s.readyout <= 1'b1;
			s.resp <= sfp_pkg::HRESP_OKAY;
		end
		else
			s <= next_s;
	end

	// Every output straight from a flip-flop
	assign hrdata = s.rdata;
	assign hreadyout = s.readyout;
	assign hresp = s.resp;
	assign pin_out = s.pin_out;
	assign pin_oe = s.pin_oe;
	assign usb_rx_data = s.usb_rx;
	assign parallel_data_in = s.pmd_in;
	assign serial_slave_select = s.ss;

endmodule // sfp_port

`default_nettype wire

// ===== verif/sfp_port_checker.sv
// Assertions on the shared port's pad and bus outputs.
// Bound to sfp_port; sees only its ports, all in the hclk domain.
`timescale 1ns/1ps
`default_nettype none

module sfp_port_checker
(
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire logic hsel, // Select
	input wire logic [11:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic hready, // Ready in
	input wire logic [31:0] hrdata, // Read data
	input wire logic [7:2] pin_out, // Pad drive
	input wire logic [7:2] pin_oe, // Pad enable
	input wire logic usb_transceiver_disable, // USB off
	input wire logic [1:0] usb_tx_oe, // USB enables
	input wire logic parallel_pin_map_select, // Map select
	input wire logic parallel_data_en, // Data port on
	input wire logic [2:0] parallel_data_out, // Data out
	input wire logic [2:0] parallel_data_oe, // Data enables
	input wire logic [2:0] parallel_data_in, // Data bits from pins
	input wire logic parallel_addr_en, // Address on pin 2
	input wire logic parallel_addr_bit5, // Address bit
	input wire logic comparator_reference_out_en, // Reference on
	input wire logic comparator_one_output, // Result
	input wire logic comparator_one_output_en // Result on pin 7
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic map;
	assign map = parallel_data_en && !parallel_pin_map_select;

	chk_ref_kills_io: assert property (
		comparator_reference_out_en |=> !pin_oe[5])
		else $error("pin 5 driven while reference is out");
	chk_ref_kills_in: assert property (
		comparator_reference_out_en |=> !parallel_data_in[2])
		else $error("pin 5 input live while reference is out");
	chk_addr_drives_pin: assert property (
		parallel_addr_en |=> pin_oe[2] && pin_out[2] == $past(parallel_addr_bit5))
		else $error("pin 2 does not carry address bit");
	chk_map_oe: assert property (
		map |=> {pin_oe[6], pin_oe[7]} == $past(parallel_data_oe[1:0]))
		else $error("parallel data enables not on pins 6 and 7");
	chk_map_data: assert property (
		map && parallel_data_oe[1:0] == 2'h3
		|=> {pin_out[6], pin_out[7]} == $past(parallel_data_out[1:0]))
		else $error("parallel data not on pins 6 and 7");
	chk_cmp_drives: assert property (
		comparator_one_output_en && !map
		|=> pin_oe[7] && pin_out[7] == $past(comparator_one_output))
		else $error("pin 7 does not carry comparator result");
	chk_usb_owns: assert property (
		!usb_transceiver_disable |=> pin_oe[4:3] == $past(usb_tx_oe))
		else $error("USB lines not steered by transceiver");
	chk_usb_off_input: assert property (
		usb_transceiver_disable |=> pin_oe[4:3] == 2'h0)
		else $error("USB pins driven while transceiver off");
	chk_low_bits_zero: assert property (
		hsel && hready && htrans == 2'h2 && !hwrite && haddr < 12'h00c
		|=> hrdata[1:0] == 2'h0)
		else $error("unimplemented port bits read nonzero");
	chk_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("read data above bit 7 nonzero");

	cover property (comparator_reference_out_en ##1 parallel_addr_en);
	cover property (map ##1 comparator_one_output_en);
	cover property (!usb_transceiver_disable && usb_tx_oe != 2'h0);
endmodule // sfp_port_checker

`default_nettype wire

// ===== verif/sfp_board_model.sv
// Board side of the six shared pads.
// Assumes the board drives every pad weakly; the port wins when enabled.
`timescale 1ns/1ps
`default_nettype none

module sfp_board_model
(
	input wire logic [7:2] pin_out, // Port drive value
	input wire logic [7:2] pin_oe, // Port drive enable
	input wire logic [7:2] ext_val, // Board level
	output logic [7:2] pin_in // Resolved pad level
);
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule // sfp_board_model

`default_nettype wire

// ===== verif/test_six_bit_shared_io_port.sv
// Self-checking bench for the six-bit shared port.
// Drives AHB-Lite and sidebands; a board model closes the pads.
`timescale 1ns/1ps
`default_nettype none

module test_six_bit_shared_io_port;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic hreadyout, usb_transceiver_disable = 1'h1, serial_slave_select;
	logic parallel_pin_map_select = 1'h1, parallel_data_en = 1'h0;
	logic parallel_addr_en = 1'h0, parallel_addr_bit5 = 1'h0;
	logic comparator_reference_out_en = 1'h0, comparator_one_output = 1'h0;
	logic comparator_one_output_en = 1'h0, dp_rd = 1'h0;
	logic [11:0] haddr = 12'h0;
	logic [1:0] htrans = 2'h0, hresp, usb_tx_data = 2'h0, usb_tx_oe = 2'h0;
	logic [1:0] usb_rx_data;
	logic [2:0] hsize = 3'h2, parallel_data_out = 3'h0;
	logic [2:0] parallel_data_oe = 3'h0, parallel_data_in;
	logic [31:0] hwdata = 32'h0, hrdata, v, rs = 32'h5123;
	logic [7:2] pin_in, pin_out, pin_oe, ext_val = 6'h0;
	logic [31:0] exq[$];
	int fail_count = 0, total_checks = 0;

	sfp_port dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_in,
		.pin_out, .pin_oe, .usb_transceiver_disable, .usb_tx_data, .usb_tx_oe,
		.usb_rx_data, .parallel_pin_map_select, .parallel_data_en,
		.parallel_data_out, .parallel_data_oe, .parallel_data_in,
		.parallel_addr_en, .parallel_addr_bit5, .comparator_reference_out_en,
		.comparator_one_output, .comparator_one_output_en, .serial_slave_select);
	sfp_board_model board_u (.pin_out, .pin_oe, .ext_val, .pin_in);

	initial
	begin
		forever #4 hclk = ~hclk;
	end

	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Bounded wait for hready; a stuck slave ends the run
	task automatic hop();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'h1 && n < 64);
		if (hreadyout !== 1'h1)
		begin
			fail_count++;
			test_done();
		end
	endtask

	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		hop();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		hop();
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		exq.push_back({24'h0, e});
		bus(1'h0, a, 8'h0);
	endtask

	// Covers two sync stages and the read prefetch
	task automatic settle();
		repeat (5) @(posedge hclk);
	endtask

	always @(posedge hclk)
	begin
		if (dp_rd)
		begin
			cmp("read", exq.pop_front(), hrdata);
			cmp("hresp", {30'h0, sfp_pkg::HRESP_OKAY}, {30'h0, hresp});
		end
		dp_rd <= hresetn && hsel && htrans == 2'h2 && !hwrite && hreadyout;
	end

	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'h1;
		v = rnd();
		ext_val <= v[5:0];
		settle();
		rd(sfp_pkg::OFF_DIRECTION, 8'hfc);
		rd(sfp_pkg::OFF_LATCH, 8'h00);
		rd(sfp_pkg::OFF_PIN_LEVELS, {ext_val, 2'h0} & 8'h98);
		cmp("pin_oe", 32'h0, {26'h0, pin_oe});
		$display("reset values done");
		v = rnd();
		bus(1'h1, sfp_pkg::OFF_PIN_LEVELS, v[7:0]);
		bus(1'h1, sfp_pkg::OFF_DIRECTION, 8'h00);
		rd(sfp_pkg::OFF_LATCH, v[7:0] & 8'hfc);
		settle();
		cmp("pin_oe", 32'h39, {26'h0, pin_oe});
		cmp("pin_out", v[7:2] & 6'h39, pin_out & 6'h39);
		rd(sfp_pkg::OFF_PIN_LEVELS, {ext_val, 2'h0} & 8'h18 | v[7:0] & 8'h80);
		$display("analog output done");
		rd(sfp_pkg::OFF_SELECT_LOW, 8'h00);
		bus(1'h1, sfp_pkg::OFF_SELECT_LOW, 8'h55);
		bus(1'h1, sfp_pkg::OFF_WATCHDOG, 8'h10);
		rd(sfp_pkg::OFF_SELECT_LOW, 8'h00);
		bus(1'h1, sfp_pkg::OFF_SELECT_LOW, 8'hff);
		bus(1'h1, sfp_pkg::OFF_SELECT_HIGH, 8'hff);
		rd(sfp_pkg::OFF_SELECT_LOW, 8'h9f);
		rd(sfp_pkg::OFF_SELECT_HIGH, 8'hfc);
		bus(1'h1, sfp_pkg::OFF_WATCHDOG, 8'h00);
		rd(sfp_pkg::OFF_SELECT_LOW, 8'h55);
		rd(12'h020, 8'h00);
		$display("shared select done");
		bus(1'h1, sfp_pkg::OFF_DIRECTION, 8'hff);
		settle();
		rd(sfp_pkg::OFF_PIN_LEVELS, {ext_val, 2'h0});
		cmp("select", {31'h0, ext_val[7]}, {31'h0, serial_slave_select});
		$display("digital input done");
		repeat (4)
		begin
			v = rnd();
			bus(1'h1, sfp_pkg::OFF_PIN_LEVELS, v[7:0]);
			bus(1'h1, sfp_pkg::OFF_DIRECTION, v[15:8]);
			settle();
			cmp("pin_oe", ~v[15:10] & 6'h39, pin_oe);
			cmp("pin_out", v[7:2] & ~v[15:10] & 6'h39,
				pin_out & ~v[15:10] & 6'h39);
		end
		$display("direction done");
		v = rnd();
		comparator_reference_out_en <= 1'h1;
		parallel_addr_en <= 1'h1;
		parallel_addr_bit5 <= v[0];
		parallel_pin_map_select <= 1'h0;
		parallel_data_en <= 1'h1;
		parallel_data_oe <= {v[3], 2'h3};
		parallel_data_out <= v[6:4];
		comparator_one_output_en <= 1'h1;
		comparator_one_output <= v[7];
		usb_transceiver_disable <= 1'h0;
		usb_tx_oe <= v[9:8];
		usb_tx_data <= v[11:10];
		settle();
		cmp("pin_oe", {2'h3, 1'h0, v[9:8], 1'h1}, pin_oe);
		cmp("data_in", {29'h0, 1'h0, v[5:4]}, {29'h0, parallel_data_in});
		cmp("usb_rx", {30'h0, v[9:8] & v[11:10] | ~v[9:8] & ext_val[4:3]},
			{30'h0, usb_rx_data});
		parallel_data_en <= 1'h0;
		settle();
		cmp("pin7", {31'h0, v[7]}, {31'h0, pin_out[7]});
		cmp("data_in", 32'h0, {29'h0, parallel_data_in});
		$display("sideband done");
		test_done();
	end

	initial
	begin
		#200000;
		fail_count++;
		test_done();
	end
endmodule // test_six_bit_shared_io_port

bind sfp_port sfp_port_checker chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hrdata, .pin_out, .pin_oe, .usb_transceiver_disable,
	.usb_tx_oe, .parallel_pin_map_select, .parallel_data_en,
	.parallel_data_out, .parallel_data_oe, .parallel_data_in, .parallel_addr_en,
	.parallel_addr_bit5, .comparator_reference_out_en,
	.comparator_one_output, .comparator_one_output_en);

`default_nettype wire
